/* File: src/amn_pkg.sv */
package amn_pkg;
	// Addresses of the message buffer and of the acknowledge / priority word
	localparam logic [31:0] MSG_BUF_ADDR_PN0 = 32'hff000010;
	localparam logic [31:0] MSG_BUF_ADDR_PN1 = 32'hff000030;
	localparam logic [31:0] ACK_ADDR_PN0 = 32'hff000000;
	localparam logic [31:0] ACK_ADDR_PN1 = 32'hff000020;
	// Message buffer shape
	localparam int MSG_WORDS = 4;
	localparam int WORD_W = 32;
	localparam logic [1:0] LAST_BEAT = 2'h3;
	// Acknowledge / priority word layout
	localparam int PRIO_W = 5;
	localparam int PRIO_LSB = 16;
	localparam int PRIO_CHG_BIT = 3;
	localparam logic [31:0] ACK_WORD = 32'h00000004;
	localparam logic [2:0] ACK_LOW_PATTERN = 3'h4;
	// Interrupt control field that selects the notify function of the shared pin
	localparam logic [7:0] NOTIFY_SEL_VALUE = 8'h00;
	// Message type field in word 0 and the vector it carries
	localparam int MSG_TYPE_LSB = 24;
	localparam int MSG_VEC_LSB = 16;
	localparam logic [7:0] MSG_TYPE_VECTOR = 8'h40;
	localparam int VEC_PRIO_LSB = 3;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		AMN_IDLE = 5'h01,
		AMN_READ = 5'h02,
		AMN_ACK = 5'h04,
		AMN_RELEASE = 5'h08,
		AMN_PRIO = 5'h10
	} amn_state_t;
endpackage : amn_pkg

/* File: src/amn_msg_store.sv */
`timescale 1ns/100ps
`default_nettype none
module amn_msg_store #(
	parameter int WORDS = amn_pkg::MSG_WORDS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Loads from the bus burst
	input wire logic bus_load,
	input wire logic [1:0] bus_idx,
	input wire logic [amn_pkg::WORD_W-1:0] bus_word,
	// Load of a whole self-addressed message
	input wire logic self_load,
	input wire logic [WORDS-1:0][amn_pkg::WORD_W-1:0] self_words,
	// Stored message
	output logic [WORDS-1:0][amn_pkg::WORD_W-1:0] words_q
);
	import amn_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// One register per word; a self message overwrites all words at once
	genvar gi;
	generate
		for (gi = 0; gi < WORDS; gi++) begin : g_word
			always_ff @(posedge sys_clk or negedge arst_n) begin
				if (!arst_n) begin
					words_q[gi] <= '0;
				end else if (self_load) begin
					words_q[gi] <= self_words[gi];
				end else if (bus_load && (bus_idx == 2'(gi))) begin
					words_q[gi] <= bus_word;
				end
			end
		end
	endgenerate
endmodule : amn_msg_store
`default_nettype wire

/* File: src/amn_int_arb.sv */
`timescale 1ns/100ps
`default_nettype none
module amn_int_arb (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Received message and current priority
	input wire logic msg_done,
	input wire logic [amn_pkg::WORD_W-1:0] msg_word0,
	input wire logic [amn_pkg::PRIO_W-1:0] cur_priority,
	// Interrupt dispatch
	output logic irq_take_q,
	output logic [7:0] irq_vector_q,
	output logic irq_posted_q
);
	import amn_pkg::*;

	logic is_vec;
	logic [7:0] vec;
	logic [PRIO_W-1:0] vec_prio;
	logic [7:0] post_vec_q;
	logic [PRIO_W-1:0] post_prio;

	// The vector's priority is its upper five bits
	assign is_vec = msg_done && (msg_word0[MSG_TYPE_LSB+:8] == MSG_TYPE_VECTOR);
	assign vec = msg_word0[MSG_VEC_LSB+:8];
	assign vec_prio = vec[VEC_PRIO_LSB+:PRIO_W];
	assign post_prio = post_vec_q[VEC_PRIO_LSB+:PRIO_W];

	////////////////////////////////////////////////////////////////////////
	// Take above current priority, else post; one posted slot, newest kept
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_take_q <= 1'b0;
			irq_vector_q <= '0;
			irq_posted_q <= 1'b0;
			post_vec_q <= '0;
		end else begin
			irq_take_q <= 1'b0;
			if (is_vec && (vec_prio > cur_priority)) begin // R16 R17
				irq_take_q <= 1'b1;
				irq_vector_q <= vec;
			end else if (is_vec) begin // R17
				irq_posted_q <= 1'b1;
				post_vec_q <= vec;
			end else if (irq_posted_q && (post_prio > cur_priority)) begin // R17
				irq_take_q <= 1'b1;
				irq_vector_q <= post_vec_q;
				irq_posted_q <= 1'b0;
			end
		end
	end

	a_high_prio_taken: assert property (@(posedge sys_clk) disable iff (!arst_n) // R17
		is_vec && (vec_prio > cur_priority) |=> irq_take_q && (irq_vector_q == $past(vec)))
		else $error("vector above current priority not taken");
	a_low_prio_posted: assert property (@(posedge sys_clk) disable iff (!arst_n) // R17
		is_vec && (vec_prio <= cur_priority) |=> !irq_take_q && irq_posted_q)
		else $error("vector at or below current priority not posted");
endmodule : amn_int_arb
`default_nettype wire

/* File: src/amn_top.sv */
// Functional notes
// R1 - Notify asserted: suspend and burst-read the four message words.
// R2 - After the burst, write one acknowledge word, then perform the message.
// R3 - Buffer read at FF000010 for processor number 0, FF000030 for 1.
// R4 - System supplies a writable four-word 32-bit message buffer.
// R5 - Acknowledge and priority writes go to FF000000 or FF000020 by number.
// R6 - Notification logic raises notify on a message, holds it until acknowledged.
// R7 - Priority sits in bits 20..16, bit 3 set marks a priority change.
// R8 - External logic drops notify on a write whose low bits are 100.
// R9 - Decode uses bit 3 to tell priority writes from acknowledges.
// R10 - Reported priority is five bits, 0 to 31, the current priority.
// R11 - With write-priority enabled, update on switch, non-message interrupt, control change.
// R12 - With external messages enabled, update when a message changes priority.
// R13 - Notify is always serviced whatever the current priority.
// R14 - System may filter messages against the external priority register.
// R15 - A message to itself is handled internally, with no bus cycles.
// R16 - A message may carry a vector, handled like a hardwired interrupt.
// R17 - Interrupts above current priority are taken, others posted.
// R18 - Shared pin acts as notify when its interrupt control field is zero.
// R19 - Notify stays asserted through priority-only writes.
`timescale 1ns/100ps
`default_nettype none
module amn_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Shared interrupt pin and its configuration
	input wire logic direct_interrupt_zero_n,
	input wire logic [7:0] direct_interrupt_zero_field,
	input wire logic local_processor_number,
	// Core state and priority events
	input wire logic [amn_pkg::PRIO_W-1:0] cur_priority,
	input wire logic write_ext_priority_en,
	input wire logic ext_msg_en,
	input wire logic process_switch,
	input wire logic non_msg_interrupt,
	input wire logic modify_process_controls_instr,
	input wire logic msg_prio_changed,
	// Self-addressed message
	input wire logic self_msg_valid,
	input wire logic [amn_pkg::MSG_WORDS-1:0][amn_pkg::WORD_W-1:0] self_msg_words,
	output logic self_msg_ready_q,
	// Local bus master port
	output logic bus_req_q,
	output logic bus_write_q,
	output logic bus_burst4_q,
	output logic [31:0] bus_addr_q,
	output logic [31:0] bus_wdata_q,
	input wire logic bus_ready,
	input wire logic [31:0] bus_rdata,
	// Message delivery to the core
	output logic core_suspend_q,
	output logic msg_done_q,
	output logic [amn_pkg::MSG_WORDS-1:0][amn_pkg::WORD_W-1:0] msg_words_q,
	output logic irq_take_q,
	output logic [7:0] irq_vector_q,
	output logic irq_posted_q
);
	import amn_pkg::*;

	amn_state_t state_q, state_d;
	logic [1:0] beat_q;
	logic prio_pend_q;
	logic notify;
	logic beat;
	logic self_take;
	logic prio_event;

	// Address selection by processor number, used in three places
	function automatic logic [31:0] amn_pick(input logic pnum, input logic [31:0] a0, input logic [31:0] a1);
		amn_pick = pnum ? a1 : a0;
	endfunction : amn_pick

	// Priority report word: priority field plus the change flag, low bits clear
	function automatic logic [31:0] amn_prio_word(input logic [PRIO_W-1:0] prio);
		logic [31:0] w;
		w = '0;
		w[PRIO_LSB+:PRIO_W] = prio;
		w[PRIO_CHG_BIT] = 1'b1;
		amn_prio_word = w;
	endfunction : amn_prio_word

	////////////////////////////////////////////////////////////////////////
	// Event decode
	// The pin only means notify while its interrupt control field selects that use
	assign notify = (direct_interrupt_zero_field == NOTIFY_SEL_VALUE) && !direct_interrupt_zero_n; // R18
	assign beat = bus_req_q && bus_ready;
	assign self_take = self_msg_valid && self_msg_ready_q && (state_q == AMN_IDLE);
	assign prio_event = (write_ext_priority_en && (process_switch || non_msg_interrupt // R11
		|| modify_process_controls_instr)) || (ext_msg_en && msg_prio_changed); // R12

	////////////////////////////////////////////////////////////////////////
	// Next state; notify wins over a waiting priority write, never masked
	always_comb begin
		state_d = state_q;
		case (state_q)
			AMN_IDLE: begin
				if (self_take) begin
					state_d = AMN_IDLE; // R15
				end else if (notify) begin
					state_d = AMN_READ; // R1 R13
				end else if (prio_pend_q) begin
					state_d = AMN_PRIO;
				end
			end
			AMN_READ: begin
				if (beat && (beat_q == LAST_BEAT)) begin
					state_d = AMN_ACK; // R2
				end
			end
			AMN_ACK: begin
				if (beat) begin
					state_d = AMN_RELEASE;
				end
			end
			AMN_RELEASE: begin
				// Waiting for the pin to drop keeps one message from being read twice
				if (!notify) begin
					state_d = AMN_IDLE;
				end
			end
			AMN_PRIO: begin
				if (beat) begin
					state_d = AMN_IDLE;
				end
			end
			default: begin
				state_d = AMN_IDLE;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State and flags
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= AMN_IDLE;
			self_msg_ready_q <= 1'b0;
			core_suspend_q <= 1'b0;
		end else begin
			state_q <= state_d;
			self_msg_ready_q <= (state_d == AMN_IDLE);
			core_suspend_q <= (state_d == AMN_READ) || (state_d == AMN_ACK); // R1
		end
	end

	// Beat counter of the message burst
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			beat_q <= '0;
		end else if (state_q != AMN_READ) begin
			beat_q <= '0;
		end else if (beat) begin
			beat_q <= beat_q + 2'h1;
		end
	end

	// Pending priority update; a new event in the issue cycle wins over the clear
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			prio_pend_q <= 1'b0;
		end else if (prio_event) begin
			prio_pend_q <= 1'b1; // R11 R12
		end else if ((state_q == AMN_IDLE) && (state_d == AMN_PRIO)) begin
			prio_pend_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus request; the priority value is sampled when the write is issued
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_req_q <= 1'b0;
			bus_write_q <= 1'b0;
			bus_burst4_q <= 1'b0;
			bus_addr_q <= '0;
			bus_wdata_q <= '0;
		end else begin
			case (state_q)
				AMN_IDLE: begin
					if (state_d == AMN_READ) begin
						bus_req_q <= 1'b1;
						bus_write_q <= 1'b0;
						bus_burst4_q <= 1'b1; // R1
						bus_addr_q <= amn_pick(local_processor_number, MSG_BUF_ADDR_PN0, MSG_BUF_ADDR_PN1); // R3
					end else if (state_d == AMN_PRIO) begin
						bus_req_q <= 1'b1;
						bus_write_q <= 1'b1;
						bus_burst4_q <= 1'b0;
						bus_addr_q <= amn_pick(local_processor_number, ACK_ADDR_PN0, ACK_ADDR_PN1); // R5
						bus_wdata_q <= amn_prio_word(cur_priority); // R7 R10
					end
				end
				AMN_READ: begin
					if (state_d == AMN_ACK) begin
						bus_write_q <= 1'b1; // R2
						bus_burst4_q <= 1'b0;
						bus_addr_q <= amn_pick(local_processor_number, ACK_ADDR_PN0, ACK_ADDR_PN1); // R5
						bus_wdata_q <= ACK_WORD;
					end
				end
				AMN_ACK, AMN_PRIO: begin
					if (beat) begin
						bus_req_q <= 1'b0;
						bus_write_q <= 1'b0;
					end
				end
				default: begin
					bus_req_q <= 1'b0;
				end
			endcase
		end
	end

	// Message hand-off once acknowledged, or at once for a self message
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			msg_done_q <= 1'b0;
		end else begin
			msg_done_q <= ((state_q == AMN_ACK) && beat) || self_take; // R2 R15
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Message storage and vector dispatch
	amn_msg_store #(
		.WORDS(MSG_WORDS)
	) u_store (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.bus_load((state_q == AMN_READ) && beat),
		.bus_idx(beat_q),
		.bus_word(bus_rdata),
		.self_load(self_take),
		.self_words(self_msg_words),
		.words_q(msg_words_q)
	);

	amn_int_arb u_arb (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.msg_done(msg_done_q),
		.msg_word0(msg_words_q[0]),
		.cur_priority(cur_priority),
		.irq_take_q(irq_take_q),
		.irq_vector_q(irq_vector_q),
		.irq_posted_q(irq_posted_q)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	// The address checks assume the processor number stays steady while a transfer runs
	a_notify_starts_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // R1
		(state_q == AMN_IDLE) && notify && !self_take |=> (state_q == AMN_READ) && bus_req_q && !bus_write_q
		&& bus_burst4_q && core_suspend_q)
		else $error("notify did not start a four-word read");
	a_read_addr_pnum: assert property (@(posedge sys_clk) disable iff (!arst_n) // R3
		(state_q == AMN_READ) |-> bus_addr_q == (local_processor_number ? MSG_BUF_ADDR_PN1 : MSG_BUF_ADDR_PN0))
		else $error("message buffer address wrong");
	a_ack_after_read: assert property (@(posedge sys_clk) disable iff (!arst_n) // R2
		(state_q == AMN_READ) && beat && (beat_q == LAST_BEAT) |=> (state_q == AMN_ACK) && bus_req_q
		&& bus_write_q && !bus_burst4_q && (bus_wdata_q[2:0] == ACK_LOW_PATTERN) && !bus_wdata_q[PRIO_CHG_BIT])
		else $error("acknowledge did not follow burst");
	a_write_addr_pnum: assert property (@(posedge sys_clk) disable iff (!arst_n) // R5
		bus_req_q && bus_write_q |-> bus_addr_q == (local_processor_number ? ACK_ADDR_PN1 : ACK_ADDR_PN0))
		else $error("acknowledge address wrong");
	a_prio_word_fmt: assert property (@(posedge sys_clk) disable iff (!arst_n) // R7
		(state_q == AMN_PRIO) |-> bus_wdata_q[PRIO_CHG_BIT] && (bus_wdata_q[2:0] == 3'h0)
		&& (bus_wdata_q[31:21] == 11'h000) && (bus_wdata_q[15:4] == 12'h000))
		else $error("priority word format wrong");
	a_prio_value: assert property (@(posedge sys_clk) disable iff (!arst_n) // R10
		(state_q == AMN_IDLE) && (state_d == AMN_PRIO) |=> bus_wdata_q[PRIO_LSB+:PRIO_W] == $past(cur_priority))
		else $error("reported priority differs");
	a_prio_event_kept: assert property (@(posedge sys_clk) disable iff (!arst_n) // R11
		write_ext_priority_en && process_switch |=> prio_pend_q)
		else $error("priority update lost");
	a_msg_prio_kept: assert property (@(posedge sys_clk) disable iff (!arst_n) // R12
		ext_msg_en && msg_prio_changed && (state_q == AMN_IDLE) && !notify |=> prio_pend_q
		##1 ((state_q == AMN_PRIO) || notify || (state_q != AMN_IDLE)))
		else $error("message priority change not reported");
	a_self_no_bus: assert property (@(posedge sys_clk) disable iff (!arst_n) // R15
		self_take |=> !bus_req_q && msg_done_q && (state_q == AMN_IDLE))
		else $error("self message used the bus");
	a_shared_pin_sel: assert property (@(posedge sys_clk) disable iff (!arst_n) // R18
		(state_q == AMN_IDLE) && (direct_interrupt_zero_field != NOTIFY_SEL_VALUE) && !prio_pend_q
		|=> (state_q == AMN_IDLE))
		else $error("pin used as notify while configured otherwise");
	a_done_after_ack: assert property (@(posedge sys_clk) disable iff (!arst_n) // R2
		(state_q == AMN_ACK) && beat |=> msg_done_q && !bus_req_q ##1 !msg_done_q)
		else $error("message hand-off missing after acknowledge");
	// Priority never masks the notify pin, even at the top level of 31
	a_notify_any_prio: assert property (@(posedge sys_clk) disable iff (!arst_n) // R13
		(state_q == AMN_IDLE) && notify && !self_take && (cur_priority == 5'h1f) |=> (state_q == AMN_READ))
		else $error("notify not serviced at top priority");
	a_suspend_span: assert property (@(posedge sys_clk) disable iff (!arst_n) // R1
		core_suspend_q == ((state_q == AMN_READ) || (state_q == AMN_ACK)))
		else $error("core suspend outside the fetch");
	a_release_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n) // R2
		(state_q == AMN_RELEASE) |-> !bus_req_q && !core_suspend_q)
		else $error("bus busy after the acknowledge");
	a_self_ready_idle: assert property (@(posedge sys_clk) disable iff (!arst_n) // R15
		self_msg_ready_q |-> (state_q == AMN_IDLE))
		else $error("self message ready while busy");
endmodule : amn_top
`default_nettype wire

/* File: bench/amn_msg_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module amn_msg_partner (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// Scenario controls from the bench
	input wire logic pnum,
	input wire logic slow,
	input wire logic post,
	input wire logic [3:0][31:0] buf_words,
	// Bus driven by the device
	input wire logic bus_req_q,
	input wire logic bus_write_q,
	input wire logic bus_burst4_q,
	input wire logic [31:0] bus_addr_q,
	input wire logic [31:0] bus_wdata_q,
	output logic bus_ready,
	output logic [31:0] bus_rdata,
	// Notify pin, priority register and tallies
	output logic notify_n_q,
	output logic [4:0] ext_prio_q,
	output logic [7:0] reads_q,
	output logic [7:0] acks_q,
	output logic [7:0] prios_q,
	output logic [7:0] bad_q
);
	import amn_pkg::*;
	logic [1:0] wait_q;
	logic [1:0] beat_q;
	logic beat;
	logic is_buf;
	logic is_ack;
	logic bad_beat;
	////////////////////////////////////////////////////////////////
	// Address decode and beat acceptance; slow mode adds two waits per beat
	assign is_buf = bus_addr_q == (pnum ? MSG_BUF_ADDR_PN1 : MSG_BUF_ADDR_PN0);
	assign is_ack = bus_addr_q == (pnum ? ACK_ADDR_PN1 : ACK_ADDR_PN0);
	assign bus_ready = bus_req_q && (!slow || wait_q == 2'h2);
	assign beat = bus_req_q && bus_ready;
	// Outside a beat the data lines show garbage, so a late sample never matches
	assign bus_rdata = bus_ready ? buf_words[beat_q] : ~buf_words[beat_q];
	// A write before the whole four-beat burst, or a stray address, is flagged
	assign bad_beat = beat && (bus_write_q ? (!is_ack || beat_q != 2'h0) : (!is_buf || !bus_burst4_q));
	////////////////////////////////////////////////////////////////
	// Wait-state counter
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) wait_q <= 2'h0;
		else if (beat) wait_q <= 2'h0;
		else if (bus_req_q) wait_q <= wait_q + 2'h1;
	end
	// Tallies of beats seen on the bus
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			beat_q <= 2'h0;
			reads_q <= 8'h00;
			acks_q <= 8'h00;
			prios_q <= 8'h00;
			bad_q <= 8'h00;
		end else begin
			if (beat && !bus_write_q) beat_q <= beat_q + 2'h1;
			if (beat && !bus_write_q) reads_q <= reads_q + 8'h01;
			if (beat && bus_write_q && bus_wdata_q[2:0] == 3'h4) acks_q <= acks_q + 8'h01;
			if (beat && bus_write_q && bus_wdata_q[3]) prios_q <= prios_q + 8'h01;
			if (bad_beat) bad_q <= bad_q + 8'h01;
		end
	end
	// Notify held low from a new message until the acknowledge pattern only
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) notify_n_q <= 1'b1;
		// Sender filter: word 0 bits 20..16 carry the message priority in this model
		else if (post && (buf_words[0][20:16] >= ext_prio_q)) notify_n_q <= 1'b0;
		else if (beat && bus_write_q && is_ack && bus_wdata_q[2:0] == 3'h4) notify_n_q <= 1'b1;
	end
	// External priority register loads only on writes qualified by bit 3
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) ext_prio_q <= 5'h00;
		else if (beat && bus_write_q && is_ack && bus_wdata_q[3]) ext_prio_q <= bus_wdata_q[20:16];
	end
endmodule : amn_msg_partner
`default_nettype wire

/* File: bench/tb_agent_message_notify_logic.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_agent_message_notify_logic;
	import amn_pkg::*;
	typedef struct packed {logic pnum; logic slow; logic [4:0] prio; logic [3:0][31:0] w;} amn_row_t;
	logic sys_clk = 1'b0, arst_n = 1'b0, direct_interrupt_zero_n, pnum = 1'b0, slow = 1'b0, post = 1'b0;
	logic [7:0] direct_interrupt_zero_field = 8'h00;
	logic [4:0] cur_priority = 5'h00;
	logic wpe = 1'b0, eme = 1'b0, self_msg_valid = 1'b0, self_msg_ready_q, bus_req_q, bus_write_q, bus_burst4_q, bus_ready;
	logic [3:0] ev = 4'h0;
	logic [3:0][31:0] self_msg_words = '0, buf_words = '0, msg_words_q;
	logic [31:0] bus_addr_q, bus_wdata_q, bus_rdata;
	logic core_suspend_q, msg_done_q, irq_take_q, irq_posted_q, got, susp_seen, req_seen;
	logic [7:0] irq_vector_q, reads_q, acks_q, prios_q, bad_q, n;
	logic [4:0] ext_prio_q;
	logic [4:0] pv [4] = '{5'h1f, 5'h00, 5'h11, 5'h0a};
	amn_row_t rows [4];
	int err_count = 0, tests_run = 0, i, r, e;
	// Clock, 8 ns period
	always #4 sys_clk = ~sys_clk;
	amn_top dut (.sys_clk, .arst_n, .direct_interrupt_zero_n, .direct_interrupt_zero_field,
		.local_processor_number(pnum),
		.cur_priority, .write_ext_priority_en(wpe), .ext_msg_en(eme), .process_switch(ev[0]),
		.non_msg_interrupt(ev[1]), .modify_process_controls_instr(ev[2]), .msg_prio_changed(ev[3]),
		.self_msg_valid, .self_msg_words, .self_msg_ready_q, .bus_req_q, .bus_write_q, .bus_burst4_q,
		.bus_addr_q, .bus_wdata_q, .bus_ready, .bus_rdata, .core_suspend_q, .msg_done_q, .msg_words_q,
		.irq_take_q, .irq_vector_q, .irq_posted_q);
	amn_msg_partner peer (.sys_clk, .arst_n, .pnum, .slow, .post, .buf_words, .bus_req_q, .bus_write_q,
		.bus_burst4_q, .bus_addr_q, .bus_wdata_q, .bus_ready, .bus_rdata, .notify_n_q(direct_interrupt_zero_n),
		.ext_prio_q, .reads_q, .acks_q, .prios_q, .bad_q);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	// Bounded wait for the one-cycle done pulse; looks before each edge so a pulse
	// launched by the caller's own edge is not missed
	task automatic wait_done();
		got = 1'b0;
		susp_seen = 1'b0;
		req_seen = 1'b0;
		for (int k = 0; k < 60 && !got; k++) begin
			#1;
			susp_seen = susp_seen | (core_suspend_q === 1'b1);
			req_seen = req_seen | (bus_req_q === 1'b1);
			got = (msg_done_q === 1'b1);
			if (!got) @(posedge sys_clk);
		end
		chk("message done", 32'h1, {31'h0, got});
	endtask : wait_done
	task automatic complete_run();
		$display("Checks run %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	// Watchdog well beyond the expected few hundred cycles
	initial begin
		#400000;
		err_count++;
		complete_run();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rows[0] = {1'b0, 1'b0, 5'h00, 128'h00000103_00000102_00000101_01000100};
		rows[1] = {1'b1, 1'b0, 5'h07, 128'hdeadbeef_12345678_80000000_00000001};
		rows[2] = {1'b0, 1'b1, 5'h10, 128'h0000ffff_ffff0000_55555555_03000002};
		rows[3] = {1'b1, 1'b1, 5'h1f, 128'hffffffff_00000000_a5a5a5a5_0200005a};
		repeat (5) @(posedge sys_clk);
		#1;
		chk("request in reset", 32'h0, {31'h0, bus_req_q});
		chk("ready in reset", 32'h0, {31'h0, self_msg_ready_q});
		@(posedge sys_clk) arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("self ready after reset", 32'h1, {31'h0, self_msg_ready_q});
		// Ordinary messages over both processor numbers, prompt and slow buffer
		for (r = 0; r < 4; r++) begin
			@(posedge sys_clk);
			pnum <= rows[r].pnum;
			slow <= rows[r].slow;
			cur_priority <= rows[r].prio;
			buf_words <= rows[r].w;
			n = reads_q;
			@(posedge sys_clk) post <= 1'b1;
			@(posedge sys_clk) post <= 1'b0;
			wait_done();
			chk("suspend seen", 32'h1, {31'h0, susp_seen});
			for (i = 0; i < 4; i++) chk("message word", rows[r].w[i], msg_words_q[i]);
			chk("read beats", n + 8'h04, reads_q);
			chk("acknowledges", r + 1, acks_q);
			chk("bad accesses", 32'h0, bad_q);
			chk("notify released", 32'h1, {31'h0, direct_interrupt_zero_n});
		end
		// Shared pin configured as a plain interrupt: no message fetch until reselected
		@(posedge sys_clk) direct_interrupt_zero_field <= 8'h01;
		n = reads_q;
		@(posedge sys_clk) post <= 1'b1;
		@(posedge sys_clk) post <= 1'b0;
		repeat (12) @(posedge sys_clk);
		#1;
		chk("reads with other pin use", n, reads_q);
		@(posedge sys_clk) direct_interrupt_zero_field <= 8'h00;
		wait_done();
		chk("reads after reselect", n + 8'h04, reads_q);
		// Priority updates from every event, then all events with enables off
		for (e = 0; e < 4; e++) begin
			n = prios_q;
			@(posedge sys_clk);
			cur_priority <= pv[e];
			wpe <= (e < 3);
			eme <= (e == 3);
			ev <= 4'h1 << e;
			@(posedge sys_clk) ev <= 4'h0;
			for (i = 0; i < 20 && prios_q == n; i++) @(posedge sys_clk);
			#1;
			chk("priority writes", n + 8'h01, prios_q);
			chk("external priority", pv[e], ext_prio_q);
			chk("notify kept high", 32'h1, {31'h0, direct_interrupt_zero_n});
		end
		n = prios_q;
		@(posedge sys_clk);
		wpe <= 1'b0;
		eme <= 1'b0;
		ev <= 4'hf;
		@(posedge sys_clk) ev <= 4'h0;
		repeat (10) @(posedge sys_clk);
		#1;
		chk("priority writes disabled", n, prios_q);
		// Self message carrying vector f8, priority 31 above current 5: taken, no bus cycles
		n = reads_q;
		@(posedge sys_clk);
		cur_priority <= 5'h05;
		self_msg_words <= {96'h0, 32'h40f80000};
		self_msg_valid <= 1'b1;
		@(posedge sys_clk) self_msg_valid <= 1'b0;
		wait_done();
		chk("bus use on self message", 32'h0, {31'h0, req_seen});
		chk("self word", 32'h40f80000, msg_words_q[0]);
		chk("reads on self message", n, reads_q);
		@(posedge sys_clk);
		#1;
		chk("vector taken", 32'h1, {31'h0, irq_take_q});
		chk("vector number", 32'hf8, irq_vector_q);
		// Vector 28 has priority 5, below current 10: posted until priority drops
		@(posedge sys_clk);
		cur_priority <= 5'h0a;
		self_msg_words <= {96'h0, 32'h40280000};
		self_msg_valid <= 1'b1;
		@(posedge sys_clk) self_msg_valid <= 1'b0;
		wait_done();
		@(posedge sys_clk);
		#1;
		chk("low vector not taken", 32'h0, {31'h0, irq_take_q});
		chk("low vector posted", 32'h1, {31'h0, irq_posted_q});
		@(posedge sys_clk) cur_priority <= 5'h02;
		got = 1'b0;
		for (i = 0; i < 10 && !got; i++) begin
			@(posedge sys_clk);
			#1;
			got = (irq_take_q === 1'b1);
		end
		chk("posted vector taken", 32'h1, {31'h0, got});
		chk("posted vector number", 32'h28, irq_vector_q);
		complete_run();
	end
endmodule : tb_agent_message_notify_logic
`default_nettype wire
